// File: pkg/bpc_regs.svh
`ifndef BPC_REGS_SVH
`define BPC_REGS_SVH
// message framing
`define BPC_MSG_REQ 8'h00
`define BPC_MSG_RSP 8'h01
// command identifiers
`define BPC_CMD_GET 8'h00
`define BPC_CMD_SET 8'h01
`define BPC_CMD_ECHO 8'h02
`define BPC_CMD_RESET 8'h03
`define BPC_CMD_ERASE_ALL 8'h04
`define BPC_CMD_ERASE_BONDS 8'h05
// secure code pair guarding both erases
`define BPC_SECURE_1 8'h55
`define BPC_SECURE_2 8'hAA
// property identifiers (offsets)
`define BPC_PROP_LATENCY 8'h0A
`define BPC_PROP_TIMEOUT 8'h0B
`define BPC_PROP_UPD_CTRL 8'h0C
// factory defaults
`define BPC_LATENCY_RST 16'h0004
`define BPC_TIMEOUT_RST 16'h01F4
`define BPC_UPD_CTRL_RST 8'h01
// field position of the send-update bit
`define BPC_UPD_SEND_BIT 0
// timing: delay before module reset, and the clock rate
`define BPC_RESET_DELAY_MS 2000
`define BPC_CLK_KHZ 200000
`define BPC_RESET_DELAY_CYC (`BPC_RESET_DELAY_MS * `BPC_CLK_KHZ)
`endif

// File: pkg/bpc_pkg.sv
package bpc_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        BPC_ST_RECV = 3'b000,
        BPC_ST_EXEC = 3'b001,
        BPC_ST_FETCH = 3'b010,
        BPC_ST_LOAD = 3'b011,
        BPC_ST_SEND = 3'b100
    } bpc_state_t;
    // response codes
    typedef enum logic [7:0] {
        BPC_RC_OK = 8'h00,
        BPC_RC_BAD_CMD = 8'h01,
        BPC_RC_BAD_PROP = 8'h02,
        BPC_RC_BAD_CODE = 8'h03,
        BPC_RC_OVERFLOW = 8'h04
    } bpc_rc_t;
endpackage

// File: hdl/bpc_echo_mem.sv
`timescale 1ns/1ps
// byte store for the incoming request; read data is registered
module bpc_echo_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // clock
    input wire logic clk_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    // read port
    input wire logic [AW-1:0] rd_addr_in,
    output logic [7:0] rd_data_out
);
    generate
        if (DEPTH < 1 || DEPTH > (1 << AW)) begin
            $error("bpc_echo_mem: depth does not fit the address width");
        end
    endgenerate

    logic [7:0] mem_q [DEPTH];

    // no reset on the array: contents are only read after being written
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_q[rd_addr_in];
    end
endmodule

// File: hdl/bpc_cmd_handler.sv
`timescale 1ns/1ps
`include "bpc_regs.svh"
// Overview of operation
// - requests carry type 0, command id, then parameters
// - responses carry type 1, response code, then returned data
// - get property returns type, code, value least significant byte first
// - set property carries id and value bytes; answered with two bytes
// - slave latency property 0x0A, two bytes, default 4, read/write
// - stored slave latency goes into the parameter update request
// - supervision timeout 0x0B, 10 ms units, default 500, sent in update
// - update control 0x0C is one byte, default 0x01, upper bits zero (a set stores all eight written bits)
// - with control bit 0 set, one update request per new connection
// - written properties persist across power loss and reset
// - new latency and timeout take effect only after next reset
// - echo returns request bytes from position two onward unchanged
// - reset command answers, then resets module two seconds later
// - erase all memory needs codes 55 AA, restores factory defaults
// - erase bonds needs codes 55 AA and removes every bond
// - after either erase completes, module resets two seconds later
module bpc_cmd_handler
    import bpc_pkg::*;
#(
    parameter int MEM_DEPTH = 64,
    parameter int RESET_DELAY_CYCLES = `BPC_RESET_DELAY_CYC
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // request byte stream
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_last_in,
    output logic rx_ready_out,
    // response byte stream
    output logic tx_valid_out,
    output logic [7:0] tx_data_out,
    output logic tx_last_out,
    input wire logic tx_ready_in,
    // non-volatile store: restore at boot, write-back, erases
    input wire logic nv_load_in,
    input wire logic [15:0] nv_latency_in,
    input wire logic [15:0] nv_timeout_in,
    input wire logic [7:0] nv_ctrl_in,
    output logic nv_write_out,
    output logic [7:0] nv_id_out,
    output logic [15:0] nv_value_out,
    output logic nv_erase_all_out,
    output logic bond_erase_out,
    input wire logic erase_done_in,
    // link side: connection events and update request
    input wire logic conn_open_in,
    output logic upd_req_out,
    output logic [15:0] upd_latency_out,
    output logic [15:0] upd_timeout_out,
    // module reset request
    output logic module_reset_out
);
    localparam int AW = $clog2(MEM_DEPTH);

    generate
        // the byte counter saturates on its top bit, so depth is a power of two
        if (MEM_DEPTH < 4 || MEM_DEPTH > 65536 ||
            MEM_DEPTH != (1 << AW) || RESET_DELAY_CYCLES < 1) begin
            $error("bpc_cmd_handler: unsupported parameter values");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // decode helpers
    ////////////////////////////////////////////////////////////////////////
    // value width in bytes of a property, zero when unknown
    function automatic logic [1:0] prop_width(input logic [7:0] id);
        case (id)
            `BPC_PROP_LATENCY: prop_width = 2'd2;
            `BPC_PROP_TIMEOUT: prop_width = 2'd2;
            `BPC_PROP_UPD_CTRL: prop_width = 2'd1;
            default: prop_width = 2'd0;
        endcase
    endfunction

    function automatic logic is_erase(input logic [7:0] cmd);
        is_erase = (cmd == `BPC_CMD_ERASE_ALL) ||
                   (cmd == `BPC_CMD_ERASE_BONDS);
    endfunction

    bpc_state_t st_q, st_d;
    logic [AW:0] cnt_q, idx_q;
    logic ovf_q;
    logic [7:0] typ_q, cmd_q, b2_q, b3_q, b4_q;
    logic [7:0] code_q, code_d;
    logic [AW:0] rlen_q, rlen_d;
    logic [15:0] lat_q, tmo_q, act_lat_q, act_tmo_q;
    logic [7:0] ctrl_q;
    logic [15:0] get_val;
    logic [7:0] mem_rdata;
    logic [31:0] tmr_q;
    logic tmr_run_q, erase_wait_q;
    logic rx_fire, tx_fire, exec_ok;

    assign rx_fire = rx_valid_in && rx_ready_out;
    assign tx_fire = tx_valid_out && tx_ready_in;
    assign exec_ok = (st_q == BPC_ST_EXEC) && (code_d == BPC_RC_OK);

    ////////////////////////////////////////////////////////////////////////
    // request capture
    ////////////////////////////////////////////////////////////////////////
    bpc_echo_mem #(
        .DEPTH(MEM_DEPTH),
        .AW(AW)
    ) u_mem (
        .clk_in(ref_clk_in),
        .wr_en_in(rx_fire && !cnt_q[AW]),
        .wr_addr_in(cnt_q[AW-1:0]),
        .wr_data_in(rx_data_in),
        .rd_addr_in(idx_q[AW-1:0]),
        .rd_data_out(mem_rdata)
    );

    // byte counter and header bytes; bytes past the buffer mark overflow
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            ovf_q <= 1'b0;
            typ_q <= 8'h00;
            cmd_q <= 8'h00;
            b2_q <= 8'h00;
            b3_q <= 8'h00;
            b4_q <= 8'h00;
        end else if (st_q == BPC_ST_SEND && st_d == BPC_ST_RECV) begin
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else if (rx_fire) begin
            if (cnt_q[AW]) begin
                ovf_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
            case (cnt_q)
                (AW+1)'(0): typ_q <= rx_data_in;
                (AW+1)'(1): cmd_q <= rx_data_in;
                (AW+1)'(2): b2_q <= rx_data_in;
                (AW+1)'(3): b3_q <= rx_data_in;
                (AW+1)'(4): b4_q <= rx_data_in;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode: response code and response length
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        code_d = BPC_RC_OK;
        rlen_d = (AW+1)'(2);
        if (typ_q != `BPC_MSG_REQ || cnt_q < (AW+1)'(2)) begin
            code_d = BPC_RC_BAD_CMD;
        end else begin
            case (cmd_q)
                `BPC_CMD_GET: begin
                    if (prop_width(b2_q) == 2'd0 || cnt_q != (AW+1)'(3)) begin
                        code_d = BPC_RC_BAD_PROP;
                    end else begin
                        rlen_d = (AW+1)'(2) + (AW+1)'(prop_width(b2_q));
                    end
                end
                `BPC_CMD_SET: begin
                    if (prop_width(b2_q) == 2'd0 ||
                        cnt_q != (AW+1)'(3) + (AW+1)'(prop_width(b2_q))) begin
                        code_d = BPC_RC_BAD_PROP;
                    end
                end
                `BPC_CMD_ECHO: begin
                    if (ovf_q) begin
                        code_d = BPC_RC_OVERFLOW;
                    end else begin
                        rlen_d = cnt_q;
                    end
                end
                `BPC_CMD_RESET: begin
                    if (cnt_q != (AW+1)'(2)) begin
                        code_d = BPC_RC_BAD_CMD;
                    end
                end
                `BPC_CMD_ERASE_ALL, `BPC_CMD_ERASE_BONDS: begin
                    // a wrong pair leaves everything intact
                    if (cnt_q != (AW+1)'(4) || b2_q != `BPC_SECURE_1 ||
                        b3_q != `BPC_SECURE_2) begin
                        code_d = BPC_RC_BAD_CODE;
                    end
                end
                default: code_d = BPC_RC_BAD_CMD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    ////////////////////////////////////////////////////////////////////////
    // one fetch cycle per response byte keeps the memory read registered
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            BPC_ST_RECV: if (rx_fire && rx_last_in) st_d = BPC_ST_EXEC;
            BPC_ST_EXEC: st_d = BPC_ST_FETCH;
            BPC_ST_FETCH: st_d = BPC_ST_LOAD;
            BPC_ST_LOAD: st_d = BPC_ST_SEND;
            BPC_ST_SEND: begin
                if (tx_ready_in) begin
                    st_d = tx_last_out ? BPC_ST_RECV : BPC_ST_FETCH;
                end
            end
            default: st_d = BPC_ST_RECV;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= BPC_ST_RECV;
            rx_ready_out <= 1'b0;
        end else begin
            st_q <= st_d;
            rx_ready_out <= (st_d == BPC_ST_RECV) && !(rx_fire && rx_last_in);
        end
    end

    // latch the outcome of the request while it is answered
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            code_q <= BPC_RC_OK;
            rlen_q <= (AW+1)'(2);
        end else if (st_q == BPC_ST_EXEC) begin
            code_q <= code_d;
            rlen_q <= rlen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // response stream
    ////////////////////////////////////////////////////////////////////////
    assign get_val = (b2_q == `BPC_PROP_LATENCY) ? lat_q :
                     (b2_q == `BPC_PROP_TIMEOUT) ? tmo_q : {8'h00, ctrl_q};

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idx_q <= '0;
            tx_valid_out <= 1'b0;
            tx_data_out <= 8'h00;
            tx_last_out <= 1'b0;
        end else begin
            if (st_q == BPC_ST_EXEC) begin
                idx_q <= '0;
            end else if (tx_fire) begin
                idx_q <= idx_q + 1'b1;
                tx_valid_out <= 1'b0;
                tx_last_out <= 1'b0;
            end
            if (st_q == BPC_ST_LOAD) begin
                tx_valid_out <= 1'b1;
                tx_last_out <= (idx_q + 1'b1 == rlen_q);
                if (idx_q == (AW+1)'(0)) begin
                    tx_data_out <= `BPC_MSG_RSP;
                end else if (idx_q == (AW+1)'(1)) begin
                    tx_data_out <= code_q;
                end else if (cmd_q == `BPC_CMD_ECHO) begin
                    tx_data_out <= mem_rdata;
                end else if (idx_q == (AW+1)'(2)) begin
                    tx_data_out <= get_val[7:0];
                end else begin
                    tx_data_out <= get_val[15:8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stored properties and write-back
    ////////////////////////////////////////////////////////////////////////
    // the store restores these at boot; writes go out to the store too
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lat_q <= `BPC_LATENCY_RST;
            tmo_q <= `BPC_TIMEOUT_RST;
            ctrl_q <= `BPC_UPD_CTRL_RST;
        end else if (nv_load_in) begin
            lat_q <= nv_latency_in;
            tmo_q <= nv_timeout_in;
            ctrl_q <= nv_ctrl_in;
        end else if (exec_ok && cmd_q == `BPC_CMD_ERASE_ALL) begin
            lat_q <= `BPC_LATENCY_RST;
            tmo_q <= `BPC_TIMEOUT_RST;
            ctrl_q <= `BPC_UPD_CTRL_RST;
        end else if (exec_ok && cmd_q == `BPC_CMD_SET) begin
            case (b2_q)
                `BPC_PROP_LATENCY: lat_q <= {b4_q, b3_q};
                `BPC_PROP_TIMEOUT: tmo_q <= {b4_q, b3_q};
                default: ctrl_q <= b3_q;
            endcase
        end
    end

    // one-cycle strobes to the store
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nv_write_out <= 1'b0;
            nv_id_out <= 8'h00;
            nv_value_out <= 16'h0000;
            nv_erase_all_out <= 1'b0;
            bond_erase_out <= 1'b0;
        end else begin
            nv_write_out <= exec_ok && cmd_q == `BPC_CMD_SET;
            if (exec_ok && cmd_q == `BPC_CMD_SET) begin
                nv_id_out <= b2_q;
                nv_value_out <= (prop_width(b2_q) == 2'd1) ?
                                {8'h00, b3_q} : {b4_q, b3_q};
            end
            nv_erase_all_out <= exec_ok && cmd_q == `BPC_CMD_ERASE_ALL;
            bond_erase_out <= exec_ok && cmd_q == `BPC_CMD_ERASE_BONDS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // connection parameter update
    ////////////////////////////////////////////////////////////////////////
    // working copies change only when the store is restored after reset
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            act_lat_q <= `BPC_LATENCY_RST;
            act_tmo_q <= `BPC_TIMEOUT_RST;
        end else if (nv_load_in) begin
            act_lat_q <= nv_latency_in;
            act_tmo_q <= nv_timeout_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            upd_req_out <= 1'b0;
            upd_latency_out <= 16'h0000;
            upd_timeout_out <= 16'h0000;
        end else begin
            upd_req_out <= conn_open_in && ctrl_q[`BPC_UPD_SEND_BIT];
            if (conn_open_in) begin
                upd_latency_out <= act_lat_q;
                upd_timeout_out <= act_tmo_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // delayed module reset
    ////////////////////////////////////////////////////////////////////////
    // a later start restarts the delay rather than queueing a second one
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            erase_wait_q <= 1'b0;
            tmr_run_q <= 1'b0;
            tmr_q <= 32'h0000_0000;
            module_reset_out <= 1'b0;
        end else begin
            module_reset_out <= 1'b0;
            if (exec_ok && is_erase(cmd_q)) begin
                erase_wait_q <= 1'b1;
            end else if (erase_wait_q && erase_done_in) begin
                erase_wait_q <= 1'b0;
            end
            if ((exec_ok && cmd_q == `BPC_CMD_RESET) ||
                (erase_wait_q && erase_done_in)) begin
                tmr_run_q <= 1'b1;
                tmr_q <= 32'(RESET_DELAY_CYCLES);
            end else if (tmr_run_q) begin
                tmr_q <= tmr_q - 32'h0000_0001;
                if (tmr_q == 32'h0000_0001) begin
                    tmr_run_q <= 1'b0;
                    module_reset_out <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    rsp_type_a: assert property (
        tx_valid_out && idx_q == (AW+1)'(0) |-> tx_data_out == `BPC_MSG_RSP)
        else $error("response type byte is not one");
    get_value_a: assert property (
        st_q == BPC_ST_LOAD && idx_q == (AW+1)'(2) && cmd_q == `BPC_CMD_GET
        && code_q == BPC_RC_OK && b2_q == `BPC_PROP_LATENCY
        |=> tx_data_out == $past(lat_q[7:0]))
        else $error("get did not return low byte first");
    set_write_a: assert property (
        exec_ok && cmd_q == `BPC_CMD_SET
        |=> nv_write_out && nv_id_out == $past(b2_q) && rlen_q == (AW+1)'(2))
        else $error("set did not write back or answer two bytes");
    lat_hold_a: assert property (
        !nv_load_in |=> act_lat_q == $past(act_lat_q)
        && act_tmo_q == $past(act_tmo_q))
        else $error("working parameters changed without reload");
    upd_once_a: assert property (
        conn_open_in && ctrl_q[0] |=> upd_req_out
        && upd_latency_out == $past(act_lat_q)
        ##1 (!upd_req_out || $past(conn_open_in)))
        else $error("update request not sent once");
    echo_len_a: assert property (
        exec_ok && cmd_q == `BPC_CMD_ECHO |=> rlen_q == $past(cnt_q))
        else $error("echo length differs from request");
    reset_arm_a: assert property (
        exec_ok && cmd_q == `BPC_CMD_RESET
        |=> tmr_run_q && tmr_q == 32'(RESET_DELAY_CYCLES))
        else $error("reset delay not armed");
    erase_guard_a: assert property (
        st_q == BPC_ST_EXEC && is_erase(cmd_q) && code_d != BPC_RC_OK
        |=> !nv_erase_all_out && !bond_erase_out && code_q != BPC_RC_OK)
        else $error("erase with bad codes not refused");
    erase_dflt_a: assert property (
        exec_ok && cmd_q == `BPC_CMD_ERASE_ALL && !nv_load_in
        |=> nv_erase_all_out && lat_q == `BPC_LATENCY_RST)
        else $error("erase all did not restore defaults");
    erase_rst_a: assert property (
        erase_wait_q && erase_done_in |=> tmr_run_q ##1 !module_reset_out)
        else $error("erase completion did not arm reset");

    get_seen_c: cover property (tx_fire && tx_last_out
        && cmd_q == `BPC_CMD_GET);
    echo_seen_c: cover property (tx_fire && cmd_q == `BPC_CMD_ECHO
        && idx_q == (AW+1)'(4));
    reset_seen_c: cover property (module_reset_out);
    bad_code_c: cover property (code_q == BPC_RC_BAD_CODE && tx_fire);
endmodule

// File: verification/bpc_store_model.sv
`timescale 1ns/1ps
`include "bpc_regs.svh"
// flash store model: keeps written values, acks erases after a delay
module bpc_store_model #(
    parameter int ERASE_CYC = 5
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // write-back and erase requests
    input wire logic wr_in,
    input wire logic [7:0] id_in,
    input wire logic [15:0] val_in,
    input wire logic erase_all_in,
    input wire logic erase_bond_in,
    // stored values and erase acknowledge
    output logic [15:0] lat_out,
    output logic [15:0] tmo_out,
    output logic [7:0] ctrl_out,
    output logic done_out
);
    int cnt_q;
    // a blank store reads back factory defaults until first written
    initial begin
        lat_out = `BPC_LATENCY_RST;
        tmo_out = `BPC_TIMEOUT_RST;
        ctrl_out = `BPC_UPD_CTRL_RST;
    end
    // contents ignore reset: a real store survives it
    always @(posedge clk_in) begin
        if (erase_all_in === 1'b1) begin
            lat_out <= `BPC_LATENCY_RST;
            tmo_out <= `BPC_TIMEOUT_RST;
            ctrl_out <= `BPC_UPD_CTRL_RST;
        end else if (wr_in === 1'b1) begin
            if (id_in == `BPC_PROP_LATENCY) lat_out <= val_in;
            if (id_in == `BPC_PROP_TIMEOUT) tmo_out <= val_in;
            if (id_in == `BPC_PROP_UPD_CTRL) ctrl_out <= val_in[7:0];
        end
    end
    // erase takes a while; done is a single pulse
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 0;
            done_out <= 1'b0;
        end else begin
            done_out <= (cnt_q == 1);
            if (erase_all_in === 1'b1 || erase_bond_in === 1'b1) begin
                cnt_q <= ERASE_CYC;
            end else if (cnt_q > 0) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule

// File: verification/ble_param_command_handler_tb.sv
`timescale 1ns/1ps
module ble_param_command_handler_tb;
    import bpc_pkg::*;
    typedef logic [7:0] bpc_b_t;
    localparam int DLY = 20;
    logic ref_clk_in = 0, rst_n_in = 0, rx_valid_in = 0, rx_last_in = 0;
    logic [7:0] rx_data_in = 8'h00, nv_ctrl, nv_id;
    logic tx_ready_in = 0, nv_load_in = 0, conn_open_in = 0, rx_ready;
    logic tx_valid, tx_last, nv_wr, era, erb, done, upd, mrst;
    logic [7:0] tx_data;
    logic [15:0] nv_lat, nv_tmo, nv_val, upd_lat, upd_tmo, lat_q, tmo_q;
    int bad_count, comparisons, cyc, n_wr, n_ea, n_eb, n_rst, n_upd;
    bpc_cmd_handler #(.MEM_DEPTH(16), .RESET_DELAY_CYCLES(DLY)) dut (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
        .rx_last_in(rx_last_in), .rx_ready_out(rx_ready),
        .tx_valid_out(tx_valid), .tx_data_out(tx_data),
        .tx_last_out(tx_last), .tx_ready_in(tx_ready_in),
        .nv_load_in(nv_load_in), .nv_latency_in(nv_lat),
        .nv_timeout_in(nv_tmo), .nv_ctrl_in(nv_ctrl),
        .nv_write_out(nv_wr), .nv_id_out(nv_id), .nv_value_out(nv_val),
        .nv_erase_all_out(era), .bond_erase_out(erb),
        .erase_done_in(done), .conn_open_in(conn_open_in),
        .upd_req_out(upd), .upd_latency_out(upd_lat),
        .upd_timeout_out(upd_tmo), .module_reset_out(mrst));
    bpc_store_model store (.clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .wr_in(nv_wr), .id_in(nv_id), .val_in(nv_val), .erase_all_in(era),
        .erase_bond_in(erb), .lat_out(nv_lat), .tmo_out(nv_tmo),
        .ctrl_out(nv_ctrl), .done_out(done));
    always #2.5 ref_clk_in = ~ref_clk_in;
    // pulse counters; watchdog cuts a hang short
    always @(posedge ref_clk_in) begin
        cyc++;
        if (nv_wr === 1'b1) n_wr++;
        if (era === 1'b1) n_ea++;
        if (erb === 1'b1) n_eb++;
        if (mrst === 1'b1) n_rst++;
        if (upd === 1'b1) begin
            n_upd++;
            lat_q = upd_lat;
            tmo_q = upd_tmo;
        end
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    // one request in, whole response out; slow stalls every response byte
    task automatic xfer(input bpc_b_t req[$], input bit slow,
                        output bpc_b_t rsp[$]);
        int w;
        logic l;
        rsp = {};
        foreach (req[i]) begin
            rx_valid_in = 1;
            rx_data_in = req[i];
            rx_last_in = (i == req.size() - 1);
            for (w = 0; rx_ready !== 1'b1 && w < 50; w++) tick(1);
            tick(1);
        end
        rx_valid_in = 0;
        rx_last_in = 0;
        do begin
            for (w = 0; tx_valid !== 1'b1 && w < 50; w++) tick(1);
            rsp.push_back(tx_data);
            if (slow) tick(3);
            if (slow) chk("held byte", tx_data, rsp[$]);
            l = tx_last;
            tx_ready_in = 1;
            tick(1);
            tx_ready_in = 0;
        end while (l !== 1'b1 && w < 50 && rsp.size() < 20);
    endtask
    task automatic run(input string what, input bpc_b_t req[$],
                       input bpc_b_t exp[$], input bit slow);
        bpc_b_t got[$];
        xfer(req, slow, got);
        chk({what, " length"}, got.size(), exp.size());
        foreach (exp[i]) if (i < got.size()) chk(what, got[i], exp[i]);
    endtask
    task automatic refused(input string what, input bpc_b_t req[$]);
        bpc_b_t got[$];
        xfer(req, 0, got);
        chk({what, " length"}, got.size(), 2);
        chk({what, " code ok"}, got[1] === 8'h00, 0);
    endtask
    task automatic conn(input int n0, input logic [15:0] lat, tmo);
        conn_open_in = 1;
        tick(1);
        conn_open_in = 0;
        tick(5);
        chk("update count", n_upd, n0 + 1);
        chk("update latency", lat_q, lat);
        chk("update timeout", tmo_q, tmo);
    endtask
    task automatic reboot();
        nv_load_in = 1;
        tick(1);
        nv_load_in = 0;
        tick(2);
    endtask
    task automatic t_defaults();
        run("get lat", {8'h00, 8'h00, 8'h0A},
            {8'h01, 8'h00, 8'h04, 8'h00}, 1);
        run("get tmo", {8'h00, 8'h00, 8'h0B},
            {8'h01, 8'h00, 8'hF4, 8'h01}, 0);
        run("get ctl", {8'h00, 8'h00, 8'h0C},
            {8'h01, 8'h00, 8'h01}, 0);
    endtask
    task automatic t_set();
        int n0 = n_wr;
        // values at the top of the host's ranges, each written only once
        run("set lat", {8'h00, 8'h01, 8'h0A, 8'hF3, 8'h01},
            {8'h01, 8'h00}, 0);
        run("set tmo", {8'h00, 8'h01, 8'h0B, 8'h80, 8'h0C},
            {8'h01, 8'h00}, 1);
        chk("store writes", n_wr, n0 + 2);
        run("reget lat", {8'h00, 8'h00, 8'h0A},
            {8'h01, 8'h00, 8'hF3, 8'h01}, 0);
        conn(n_upd, 16'h0004, 16'h01F4);
        reboot();
        conn(n_upd, 16'h01F3, 16'h0C80);
        run("ctl off", {8'h00, 8'h01, 8'h0C, 8'h00},
            {8'h01, 8'h00}, 0);
        reboot();
        n0 = n_upd;
        conn_open_in = 1;
        tick(1);
        conn_open_in = 0;
        tick(5);
        chk("no update", n_upd, n0);
    endtask
    task automatic t_misc();
        int n0 = n_rst;
        bpc_b_t big[$] = {8'h00, 8'h02};
        run("echo", {8'h00, 8'h02, 8'h01, 8'h02, 8'h03},
            {8'h01, 8'h00, 8'h01, 8'h02, 8'h03}, 1);
        refused("bad cmd", {8'h00, 8'h07});
        refused("bad prop", {8'h00, 8'h00, 8'h0D});
        // more bytes than the request buffer holds cannot be echoed
        repeat (16) big.push_back(8'h5A);
        refused("overflow", big);
        refused("bad type", {8'h01, 8'h00, 8'h0A});
        run("reset", {8'h00, 8'h03}, {8'h01, 8'h00}, 0);
        chk("early reset", n_rst, n0);
        tick(DLY + 10);
        chk("module reset", n_rst, n0 + 1);
    endtask
    task automatic t_erase();
        int a0 = n_ea;
        int b0 = n_eb;
        int r0 = n_rst;
        refused("bad code", {8'h00, 8'h04, 8'h55, 8'h00});
        refused("swapped", {8'h00, 8'h05, 8'hAA, 8'h55});
        chk("no erase", n_ea + n_eb, a0 + b0);
        run("bonds", {8'h00, 8'h05, 8'h55, 8'hAA}, {8'h01, 8'h00}, 0);
        tick(DLY + 20);
        chk("bond erase", n_eb, b0 + 1);
        chk("bond reset", n_rst, r0 + 1);
        run("erase", {8'h00, 8'h04, 8'h55, 8'hAA}, {8'h01, 8'h00}, 0);
        tick(DLY + 20);
        chk("full erase", n_ea, a0 + 1);
        chk("erase reset", n_rst, r0 + 2);
        t_defaults();
    endtask
    initial begin
        tick(12);
        rst_n_in = 1;
        tick(2);
        t_defaults();
        t_set();
        t_misc();
        t_erase();
        close_out();
    end
endmodule
